/* File: hw/pfc_front_end_ctrl.sv */
`timescale 1ns/1ps
// ============================================================================
// Notes on behaviour
// - three 8-bit gain codes, 0 is 0.5 V span, 255 is 1.0 V span
// - three independent 7-bit offset codes covering plus or minus 63 LSB
// - offset step follows span, 2 mV at smallest, 4 mV at doubled span
// - green sync threshold is bits 7..3 of 0FH, nominal 150 mV
// - green embedded sync is always taken as negative polarity
// - divisor from 01H and 02H divides pixel clock, compared against line sync
// - divider counts divisor plus one cycles per period
// - 03H bits 7..6 pick oscillator range
// - 03H bits 5..3 pick pump current from 50 to 1500 microamps
// - 04H bits 7..3 pick one of 32 sampling phase steps
// - regenerated line sync carries the same phase shift
// - during coast the loop ignores line sync and holds frequency
// - 10H bit 6 sets assumed incoming line sync polarity
// - the COAST input gates off the loop reference so oscillator free-runs
// - every control field is reached through the 2-wire serial port
module pfc_front_end_ctrl
  import pfc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic LINE_SYNC_IN,
  input wire logic COAST,
  output logic REGEN_LINE_SYNC_OUT,
  output logic FB_PULSE,
  output logic [11:0] FB_DIVISOR,
  output logic PD_UP,
  output logic PD_DN,
  output logic [4:0] PHASE_TAP,
  output logic [1:0] OSC_RANGE_FIELD,
  output logic [2:0] PUMP_SEL,
  output logic [10:0] PUMP_UA,
  output logic [4:0] SOG_THRESH,
  output logic GREEN_EMBEDDED_SYNC_NEG,
  output logic LINE_SYNC_POL,
  output logic [7:0] GAIN_R,
  output logic [7:0] GAIN_G,
  output logic [7:0] GAIN_B,
  output logic [6:0] SHIFT_R,
  output logic [6:0] SHIFT_G,
  output logic [6:0] SHIFT_B,
  output logic [11:0] STEP_UV_R,
  output logic [11:0] STEP_UV_G,
  output logic [11:0] STEP_UV_B
);
  pfc_link_if lnk ();

  // ==========================================================================
  // pin synchronisers
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, hs_s1, hs_s2;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge CLK) begin
    if (RST) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
      {hs_s1, hs_s2} <= 2'h0;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {SCL_IN, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {SDA_IN, sda_s1, sda_s2};
      {hs_s1, hs_s2} <= {LINE_SYNC_IN, hs_s1};
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ==========================================================================
  // register storage declarations
  logic [11:0] divisor, next_divisor;
  logic [1:0] osc_range, next_osc_range;
  logic [2:0] pump_sel, next_pump_sel;
  logic [4:0] phase_pend, next_phase_pend;
  logic [4:0] sog_thr, next_sog_thr;
  logic hs_pol, next_hs_pol;
  logic [7:0] gain [NUM_CH];
  logic [7:0] next_gain [NUM_CH];
  logic [6:0] shift [NUM_CH];
  logic [6:0] next_shift [NUM_CH];
  logic [4:0] phase_tap, next_phase_tap;
  logic pd_up, next_pd_up, pd_dn, next_pd_dn;

  function automatic logic [7:0] rd_word(input logic [7:0] a);
    rd_word = 8'h00;
    case (a)
      REG_DIV_HI: rd_word = divisor[11:4];
      REG_DIV_LO: rd_word = {divisor[3:0], 4'h0};
      REG_RANGE_PUMP: rd_word = {osc_range, pump_sel, 3'h0};
      REG_PHASE: rd_word = {phase_pend, 3'h0};
      REG_SOG_THR: rd_word = {sog_thr, 3'h0};
      REG_SYNC_POL: rd_word = {1'b0, hs_pol, 6'h00};
      REG_STATUS: rd_word = {phase_tap, pd_dn, pd_up, COAST};
      default: begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (a == GAIN_ADDR[c]) rd_word = gain[c];
          if (a == SHIFT_ADDR[c]) rd_word = {1'b0, shift[c]};
        end
      end
    endcase
  endfunction

  // ==========================================================================
  // 2-wire serial slave
  pfc_i2c_e state, next_state;
  logic [3:0] bits, next_bits;
  logic [7:0] shreg, next_shreg, ptr, next_ptr, wr_addr, wr_data, rd_byte;
  logic rd_mode, next_rd_mode, sda_oe, next_sda_oe, sda_low, wr_en;

  assign wr_addr = ptr;
  assign wr_data = shreg;
  always_comb rd_byte = rd_word(ptr);

  always_comb begin
    next_state = state;
    next_bits = bits;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rd_mode = rd_mode;
    next_sda_oe = sda_oe;
    wr_en = 1'b0;
    if (bus_stop) begin
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (bus_start) begin
      next_state = ST_ADDR;
      next_bits = 4'h0;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s2};
            next_bits = bits + 4'h1;
          end else if (scl_fall && bits == BYTE_BITS) begin
            next_bits = 4'h0;
            next_sda_oe = 1'b1;
            if (state == ST_ADDR) begin
              next_rd_mode = shreg[0];
              next_state = ST_ADDR_ACK;
              if (shreg[7:1] != DEV_ADDR) begin
                next_state = ST_IDLE;
                next_sda_oe = 1'b0;
              end
            end else if (state == ST_PTR) begin
              next_ptr = shreg;
              next_state = ST_PTR_ACK;
            end else begin
              wr_en = 1'b1;
              next_state = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          if (state == ST_RDATA_ACK && scl_rise && sda_s2) begin
            next_state = ST_IDLE;
          end else if (scl_fall && (rd_mode || state == ST_RDATA_ACK)) begin
            next_state = ST_RDATA;
            next_shreg = rd_byte;
            next_sda_oe = ~rd_byte[7];
            next_bits = 4'h0;
          end else if (scl_fall) begin
            next_state = ST_PTR;
            next_sda_oe = 1'b0;
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_state = ST_WDATA;
            next_sda_oe = 1'b0;
            if (state == ST_WDATA_ACK) next_ptr = ptr + 8'h01;
          end
        end
        ST_RDATA: begin
          if (scl_fall && bits == LAST_BIT) begin
            next_state = ST_RDATA_ACK;
            next_sda_oe = 1'b0;
            next_ptr = ptr + 8'h01;
          end else if (scl_fall) begin
            next_shreg = {shreg[6:0], 1'b0};
            next_sda_oe = ~shreg[6];
            next_bits = bits + 4'h1;
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ST_IDLE;
      bits <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rd_mode <= 1'b0;
      sda_oe <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      state <= next_state;
      bits <= next_bits;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rd_mode <= next_rd_mode;
      sda_oe <= next_sda_oe;
      sda_low <= 1'b0;
    end
  end

  // ==========================================================================
  // register file
  always_comb begin
    next_divisor = divisor;
    next_osc_range = osc_range;
    next_pump_sel = pump_sel;
    next_phase_pend = phase_pend;
    next_sog_thr = sog_thr;
    next_hs_pol = hs_pol;
    next_gain = gain;
    next_shift = shift;
    if (wr_en) begin
      case (wr_addr)
        REG_DIV_HI: next_divisor[11:4] = wr_data;
        REG_DIV_LO: next_divisor[3:0] = wr_data[DIV_LO_MSB:DIV_LO_LSB];
        REG_RANGE_PUMP: begin
          next_osc_range = wr_data[RANGE_MSB:RANGE_LSB];
          next_pump_sel = wr_data[PUMP_MSB:PUMP_LSB];
        end
        REG_PHASE: next_phase_pend = wr_data[PHASE_MSB:PHASE_LSB];
        REG_SOG_THR: next_sog_thr = wr_data[SOG_MSB:SOG_LSB];
        REG_SYNC_POL: next_hs_pol = wr_data[HS_POL_BIT];
        default: begin
          for (int c = 0; c < NUM_CH; c++) begin
            if (wr_addr == GAIN_ADDR[c]) next_gain[c] = wr_data;
            if (wr_addr == SHIFT_ADDR[c]) next_shift[c] = wr_data[6:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      divisor <= DIV_RST;
      osc_range <= RANGE_RST;
      pump_sel <= PUMP_RST;
      phase_pend <= PHASE_RST;
      sog_thr <= SOG_THR_RST;
      hs_pol <= HS_POL_RST;
      for (int c = 0; c < NUM_CH; c++) begin
        gain[c] <= GAIN_RST;
        shift[c] <= SHIFT_RST;
      end
    end else begin
      divisor <= next_divisor;
      osc_range <= next_osc_range;
      pump_sel <= next_pump_sel;
      phase_pend <= next_phase_pend;
      sog_thr <= next_sog_thr;
      hs_pol <= next_hs_pol;
      gain <= next_gain;
      shift <= next_shift;
    end
  end

  // ==========================================================================
  // loop reference, phase detector and phase apply
  logic hs_level, hs_level_d, ref_edge, next_hs_level;
  logic [10:0] pump_ua, next_pump_ua;

  assign ref_edge = hs_level & ~hs_level_d & ~COAST;

  always_comb begin
    next_hs_level = hs_pol ? hs_s2 : ~hs_s2;
    next_pd_up = pd_up | ref_edge;
    next_pd_dn = pd_dn | lnk.fb_pulse;
    if (next_pd_up && next_pd_dn) begin
      next_pd_up = 1'b0;
      next_pd_dn = 1'b0;
    end
    if (COAST) begin
      next_pd_up = 1'b0;
      next_pd_dn = 1'b0;
    end
    next_phase_tap = lnk.fb_pulse ? phase_pend : phase_tap;
    next_pump_ua = PUMP_UA_TABLE[pump_sel];
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      hs_level <= 1'b0;
      hs_level_d <= 1'b0;
      pd_up <= 1'b0;
      pd_dn <= 1'b0;
      phase_tap <= PHASE_RST;
      pump_ua <= PUMP_UA_TABLE[PUMP_RST];
    end else begin
      hs_level <= next_hs_level;
      hs_level_d <= hs_level;
      pd_up <= next_pd_up;
      pd_dn <= next_pd_dn;
      phase_tap <= next_phase_tap;
      pump_ua <= next_pump_ua;
    end
  end

  // ==========================================================================
  // offset step scaled by span, one per channel
  logic [11:0] step [NUM_CH];

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_step
    logic [11:0] next_step;
    always_comb begin
      next_step = 12'(OFS_STEP_MIN_UV + (20'(gain[ch]) * OFS_STEP_SPAN_UV) / GAIN_FULL);
    end
    always_ff @(posedge CLK) begin
      if (RST) step[ch] <= OFS_STEP_MIN_UV[11:0];
      else step[ch] <= next_step;
    end
  end

  // ==========================================================================
  // submodules and outputs
  assign lnk.divisor = divisor;
  assign lnk.hs_level = hs_level;
  assign lnk.phase_tap = phase_tap;

  pfc_fb_divider u_div (.clk(CLK), .rst(RST), .lnk(lnk.div));
  pfc_hs_delay u_dly (.clk(CLK), .rst(RST), .lnk(lnk.dly));

  assign SDA_OUT = sda_low;
  assign SDA_OE = sda_oe;
  assign REGEN_LINE_SYNC_OUT = lnk.hs_regen;
  assign FB_PULSE = lnk.fb_pulse;
  assign FB_DIVISOR = divisor;
  assign PD_UP = pd_up;
  assign PD_DN = pd_dn;
  assign PHASE_TAP = phase_tap;
  assign OSC_RANGE_FIELD = osc_range;
  assign PUMP_SEL = pump_sel;
  assign PUMP_UA = pump_ua;
  assign SOG_THRESH = sog_thr;
  assign GREEN_EMBEDDED_SYNC_NEG = 1'b1;
  assign LINE_SYNC_POL = hs_pol;
  assign {GAIN_R, GAIN_G, GAIN_B} = {gain[0], gain[1], gain[2]};
  assign {SHIFT_R, SHIFT_G, SHIFT_B} = {shift[0], shift[1], shift[2]};
  assign {STEP_UV_R, STEP_UV_G, STEP_UV_B} = {step[0], step[1], step[2]};

  // ==========================================================================
  // checks
  property p_addr_ack;
    @(posedge CLK) disable iff (RST)
      (state == ST_ADDR && scl_fall && bits == BYTE_BITS && shreg[7:1] == DEV_ADDR
       && !bus_start && !bus_stop) |=> (state == ST_ADDR_ACK && SDA_OE);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

  property p_div_write;
    @(posedge CLK) disable iff (RST)
      (wr_en && wr_addr == REG_DIV_HI) |=> FB_DIVISOR[11:4] == $past(wr_data);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divisor write lost");

  property p_range_write;
    @(posedge CLK) disable iff (RST)
      (wr_en && wr_addr == REG_RANGE_PUMP && wr_data == 8'h68)
        |=> OSC_RANGE_FIELD == 2'h1 && PUMP_SEL == 3'h5 ##1 PUMP_UA == 11'h1F4;
  endproperty
  a_range_write: assert property (p_range_write) else $error("range or pump wrong");

  property p_coast_gate;
    @(posedge CLK) disable iff (RST)
      COAST |=> (!PD_UP && !PD_DN);
  endproperty
  a_coast_gate: assert property (p_coast_gate) else $error("loop steered in coast");

  property p_phase_hold;
    @(posedge CLK) disable iff (RST)
      !FB_PULSE |=> $stable(PHASE_TAP);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase moved off safe point");

  property p_phase_apply;
    @(posedge CLK) disable iff (RST)
      FB_PULSE |=> PHASE_TAP == $past(phase_pend);
  endproperty
  a_phase_apply: assert property (p_phase_apply) else $error("phase not applied");

  property p_step_full;
    @(posedge CLK) disable iff (RST)
      (GAIN_R == 8'hFF && $past(GAIN_R) == 8'hFF) |-> STEP_UV_R == 12'hFA0;
  endproperty
  a_step_full: assert property (p_step_full) else $error("offset step not doubled");

  c_write: cover property (@(posedge CLK) disable iff (RST) wr_en && wr_addr == REG_PHASE);
  c_read: cover property (@(posedge CLK) disable iff (RST) state == ST_RDATA_ACK && scl_rise);
  c_coast: cover property (@(posedge CLK) disable iff (RST) $rose(COAST));
  c_lockstep: cover property (@(posedge CLK) disable iff (RST) ref_edge && FB_PULSE);
endmodule // pfc_front_end_ctrl

/* File: hw/pfc_pkg.sv */
package pfc_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_CH = 3;
  localparam int PHASE_STEPS = 32;

  // ==========================================================================
  // serial port
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h4C; // arbitrary value
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] REG_DIV_HI = 8'h01;
  localparam logic [7:0] REG_DIV_LO = 8'h02;
  localparam logic [7:0] REG_RANGE_PUMP = 8'h03;
  localparam logic [7:0] REG_PHASE = 8'h04;
  localparam logic [7:0] REG_SOG_THR = 8'h0F;
  localparam logic [7:0] REG_SYNC_POL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] GAIN_ADDR [NUM_CH] = '{8'h08, 8'h09, 8'h0A};
  localparam logic [7:0] SHIFT_ADDR [NUM_CH] = '{8'h0B, 8'h0C, 8'h0D};

  // ==========================================================================
  // field positions
  localparam int RANGE_MSB = 7;
  localparam int RANGE_LSB = 6;
  localparam int PUMP_MSB = 5;
  localparam int PUMP_LSB = 3;
  localparam int PHASE_MSB = 7;
  localparam int PHASE_LSB = 3;
  localparam int SOG_MSB = 7;
  localparam int SOG_LSB = 3;
  localparam int HS_POL_BIT = 6;
  localparam int DIV_LO_MSB = 7;
  localparam int DIV_LO_LSB = 4;

  // ==========================================================================
  // values after reset
  localparam logic [11:0] DIV_RST = 12'h3FF;
  localparam logic [1:0] RANGE_RST = 2'h0;
  localparam logic [2:0] PUMP_RST = 3'h0;
  localparam logic [4:0] PHASE_RST = 5'h00;
  localparam logic [4:0] SOG_THR_RST = 5'h10;
  localparam logic HS_POL_RST = 1'b1;
  localparam logic [7:0] GAIN_RST = 8'h80;
  localparam logic [6:0] SHIFT_RST = 7'h40;

  // ==========================================================================
  // lookup and scaling
  localparam logic [10:0] PUMP_UA_TABLE [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
                                                11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
  localparam logic [19:0] OFS_STEP_MIN_UV = 20'h007D0;
  localparam logic [19:0] OFS_STEP_SPAN_UV = 20'h007D0;
  localparam logic [19:0] GAIN_FULL = 20'h000FF;

  // ==========================================================================
  // serial port states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ADDR_ACK  = 4'b0011,
    ST_PTR       = 4'b0010,
    ST_PTR_ACK   = 4'b0110,
    ST_WDATA     = 4'b0111,
    ST_WDATA_ACK = 4'b0101,
    ST_RDATA     = 4'b0100,
    ST_RDATA_ACK = 4'b1100
  } pfc_i2c_e;

endpackage

/* File: hw/pfc_link_if.sv */
`timescale 1ns/1ps
interface pfc_link_if;
  logic [11:0] divisor;
  logic fb_pulse;
  logic hs_level;
  logic [4:0] phase_tap;
  logic hs_regen;
  modport top (output divisor, output hs_level, output phase_tap,
               input fb_pulse, input hs_regen);
  modport div (input divisor, output fb_pulse);
  modport dly (input hs_level, input phase_tap, output hs_regen);
endinterface

/* File: hw/pfc_fb_divider.sv */
`timescale 1ns/1ps
module pfc_fb_divider
  import pfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pfc_link_if.div lnk
);
  logic [11:0] count;
  logic [11:0] next_count;
  logic pulse;
  logic next_pulse;

  // ==========================================================================
  // reload counter, divisor plus one cycles per period
  always_comb begin
    next_count = count + 12'h001;
    next_pulse = 1'b0;
    if (count >= lnk.divisor) begin
      next_count = 12'h000;
      next_pulse = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 12'h000;
      pulse <= 1'b0;
    end else begin
      count <= next_count;
      pulse <= next_pulse;
    end
  end

  assign lnk.fb_pulse = pulse;

  // ==========================================================================
  // checks
  property p_fb_reload;
    @(posedge clk) disable iff (rst)
      (count == lnk.divisor) |=> (lnk.fb_pulse && count == 12'h000);
  endproperty
  a_fb_reload: assert property (p_fb_reload) else $error("divider missed reload");

  property p_fb_single;
    @(posedge clk) disable iff (rst)
      (lnk.fb_pulse && lnk.divisor > 12'h001 && $stable(lnk.divisor)) |=> !lnk.fb_pulse;
  endproperty
  a_fb_single: assert property (p_fb_single) else $error("compare pulse too long");

  // cycles since last pulse, divisor unchanged since then
  logic [12:0] since;
  logic [12:0] next_since;
  logic [11:0] div_seen;
  logic div_held;
  logic next_div_held;

  always_comb begin
    next_since = lnk.fb_pulse ? 13'h0001 : since + 13'h0001;
    next_div_held = lnk.fb_pulse | (div_held & (lnk.divisor == div_seen));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      since <= 13'h0000;
      div_seen <= 12'h000;
      div_held <= 1'b0;
    end else begin
      since <= next_since;
      div_seen <= lnk.divisor;
      div_held <= next_div_held;
    end
  end

  property p_fb_gap;
    @(posedge clk) disable iff (rst)
      (lnk.fb_pulse && div_held) |-> since == {1'b0, div_seen} + 13'h0001;
  endproperty
  a_fb_gap: assert property (p_fb_gap) else $error("divided period wrong");
endmodule // pfc_fb_divider

/* File: hw/pfc_hs_delay.sv */
`timescale 1ns/1ps
module pfc_hs_delay
  import pfc_pkg::*;
#(
  parameter int TAPS = PHASE_STEPS
) (
  input wire logic clk,
  input wire logic rst,
  pfc_link_if.dly lnk
);
  logic [TAPS-1:0] line;
  logic [TAPS-1:0] next_line;
  logic regen;
  logic next_regen;

  // ==========================================================================
  // tapped delay line, same tap as sampling phase
  always_comb begin
    next_line = {line[TAPS-2:0], lnk.hs_level};
    next_regen = line[lnk.phase_tap];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      line <= '0;
      regen <= 1'b0;
    end else begin
      line <= next_line;
      regen <= next_regen;
    end
  end

  assign lnk.hs_regen = regen;

  // ==========================================================================
  // checks
  property p_regen_tap0;
    @(posedge clk) disable iff (rst)
      (lnk.phase_tap == 5'h00 && $past(lnk.phase_tap) == 5'h00 && !$past(rst) && !$past(rst, 2))
        |-> lnk.hs_regen == $past(lnk.hs_level, 2);
  endproperty
  a_regen_tap0: assert property (p_regen_tap0) else $error("sync out delay wrong");
endmodule // pfc_hs_delay

/* File: verification/pfc_sync_src.sv */
`timescale 1ns/1ps
// ==========================================================================
// line sync source
module pfc_sync_src #(
  parameter int PER = 700,
  parameter int WID = 40
) (
  input wire logic clk,
  input wire logic act_high,
  output logic sync = 1'b0
);
  int cnt = 0;
  always @(negedge clk) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    sync <= ((cnt < WID) == act_high);
  end
endmodule // pfc_sync_src

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
// ==========================================================================
// bench top
module tb_top;
  import pfc_pkg::*;
  localparam int SPER = 700;
  localparam int SWID = 40;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic COAST = 1'b0;
  logic act_high = 1'b1;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic sync, sda, sda_out, sda_oe, regen, fbp, pd_up, pd_dn, neg, pol;
  logic [11:0] div, ur, ug, ub;
  logic [4:0] tap, green_embedded_sync;
  logic [1:0] rng;
  logic [2:0] pump;
  logic [10:0] ua;
  logic [7:0] gr, gg, gb;
  logic [6:0] sr, sg, sb;
  logic [31:0] lf = 32'h00014F9B;
  int miscompares = 0;
  int n_checks = 0;
  int mg[3], ms[3];
  int uat[8] = '{50, 100, 150, 250, 350, 500, 750, 1500};
  assign sda = (sda_oe === 1'b1) ? sda_out : sda_m;
  pfc_sync_src #(.PER(SPER), .WID(SWID)) src_u (.clk(CLK), .act_high(act_high), .sync(sync));
  pfc_front_end_ctrl dut_u (.CLK(CLK), .RST(RST), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .LINE_SYNC_IN(sync), .COAST(COAST),
    .REGEN_LINE_SYNC_OUT(regen), .FB_PULSE(fbp), .FB_DIVISOR(div), .PD_UP(pd_up),
    .PD_DN(pd_dn), .PHASE_TAP(tap), .OSC_RANGE_FIELD(rng), .PUMP_SEL(pump), .PUMP_UA(ua),
    .SOG_THRESH(green_embedded_sync), .GREEN_EMBEDDED_SYNC_NEG(neg), .LINE_SYNC_POL(pol), .GAIN_R(gr),
    .GAIN_G(gg), .GAIN_B(gb), .SHIFT_R(sr), .SHIFT_G(sg), .SHIFT_B(sb), .STEP_UV_R(ur),
    .STEP_UV_G(ug), .STEP_UV_B(ub));
  initial forever #25 CLK = ~CLK;
  // ==========================================================================
  // helpers
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tk(int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic rise(ref logic s, output int n);
    logic p;
    n = 0;
    do begin
      p = s;
      tk(1);
      n++;
    end while (!(p === 1'b0 && s === 1'b1) && n < 6000);
    chk("edge seen", 1, p === 1'b0 && s === 1'b1);
  endtask
  // ==========================================================================
  // serial master
  task automatic bt(logic b, output logic q);
    sda_m = b;
    tk(6);
    scl = 1'b1;
    tk(3);
    q = sda;
    tk(3);
    scl = 1'b0;
    tk(1);
  endtask
  task automatic byt(logic [7:0] d, logic ack, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(1'b1, a);
    if (ack) chk("ack", 0, a);
  endtask
  task automatic cond(logic p);
    sda_m = p;
    tk(6);
    scl = 1'b1;
    tk(6);
    sda_m = ~p;
    tk(6);
    scl = ~p;
    tk(1);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [7:0] q;
    cond(1'b1);
    byt({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q);
    byt(a, 1'b1, q);
    byt(d, 1'b1, q);
    cond(1'b0);
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] q);
    cond(1'b1);
    byt({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q);
    byt(a, 1'b1, q);
    cond(1'b1);
    byt({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, q);
    byt(8'hFF, 1'b0, q);
    cond(1'b0);
  endtask
  // ==========================================================================
  // tests
  initial begin
    #(90000 * 50);
    miscompares++;
    end_of_test;
  end
  initial begin
    int n, d0, dp;
    logic [7:0] q;
    logic [11:0] d;
    logic [4:0] ph;
    tk(12);
    RST = 1'b0;
    tk(4);
    chk("div rst", DIV_RST, div);
    chk("green sync neg", 1, neg);
    rise(sync, n);
    rise(regen, d0);
    ph = lf[4:0];
    wr(REG_PHASE, {lf[4:0], 3'h0});
    rise(fbp, n);
    rise(fbp, n);
    chk("tap", lf[4:0], tap);
    rise(sync, n);
    rise(regen, dp);
    chk("sync shift", lf[4:0], dp - d0);
    $display("test phase done");
    for (int c = 0; c < 3; c++) begin
      lf = nx(lf);
      mg[c] = c == 0 ? 255 : c == 1 ? 0 : lf[7:0];
      ms[c] = lf[14:8];
      wr(GAIN_ADDR[c], mg[c][7:0]);
      wr(SHIFT_ADDR[c], {1'b0, lf[14:8]});
    end
    wr(REG_SOG_THR, {lf[20:16], 3'h0});
    tk(2);
    chk("sog", lf[20:16], green_embedded_sync);
    for (int c = 0; c < 3; c++) begin
      chk("gain", mg[c], c == 0 ? gr : c == 1 ? gg : gb);
      chk("shift", ms[c], c == 0 ? sr : c == 1 ? sg : sb);
      chk("step", 2000 + mg[c] * 2000 / 255, c == 0 ? ur : c == 1 ? ug : ub);
    end
    rd(GAIN_ADDR[2], q);
    chk("gain read", mg[2], q);
    rd(8'h20, q);
    chk("unmapped read", 0, q);
    $display("test gain done");
    for (int c = 0; c < 8; c++) begin
      wr(REG_RANGE_PUMP, {2'(c % 3), 3'(c), 3'h0});
      tk(2);
      chk("range", c % 3, rng);
      chk("pump", c, pump);
      chk("pump ua", uat[c], ua);
    end
    wr(REG_RANGE_PUMP, 8'h68);
    $display("test pump done");
    for (int k = 0; k < 2; k++) begin
      lf = nx(lf);
      d = k == 0 ? 12'd221 : 12'(221 + lf % 3875);
      wr(REG_DIV_HI, d[11:4]);
      wr(REG_DIV_LO, {d[3:0], 4'h0});
      chk("divisor", d, div);
      rise(fbp, n);
      rise(fbp, n);
      tk(1);
      chk("pulse width", 0, fbp);
      rise(fbp, n);
      chk("period", d + 1, n + 1);
    end
    $display("test divider done");
    for (int k = 1; k >= 0; k--) begin
      act_high = k[0];
      wr(REG_SYNC_POL, {1'b0, k[0], 6'h00});
      tk(2 * SPER);
      n = 0;
      repeat (SPER) begin
        tk(1);
        n += (regen === 1'b1);
      end
      chk("sync width", SWID, n);
      chk("pol", k, pol);
    end
    $display("test polarity done");
    for (int k = 0; k < 2; k++) begin
      COAST = k[0];
      tk(50);
      n = 0;
      repeat (3000) begin
        tk(1);
        n += ((pd_up | pd_dn) === 1'b1);
      end
      chk("detector active", k == 0, k == 0 ? n > 0 : n);
    end
    rd(REG_STATUS, q);
    chk("status", {ph, 3'h1}, q);
    $display("test coast done");
    end_of_test;
  end
endmodule // tb_top
